// File: common/scm_pkg.sv
`default_nettype none
package scm_pkg;
	// register byte offsets on the bus
	localparam logic [7:0] SCM_OFS_CLKCFG = 8'h00;
	localparam logic [7:0] SCM_OFS_MODE = 8'h04;
	localparam logic [7:0] SCM_OFS_STAT = 8'h08;
	// reset values
	localparam logic [15:0] SCM_CLKCFG_RST = 16'h0004;
	localparam logic [15:0] SCM_MODE_RST = 16'h0000;
	// channel_clock_config fields
	localparam int SCM_CFG_QUARTER = 0;
	localparam int SCM_CFG_DIV_LO = 1;
	localparam int SCM_CFG_DIV_HI = 11;
	localparam int SCM_CFG_RXPIN = 12;
	localparam int SCM_CFG_TXPIN = 13;
	localparam int SCM_CFG_TIMER = 14;
	// serial_channel_mode fields
	localparam int SCM_MD_PROT_LO = 0;
	localparam int SCM_MD_PROT_HI = 1;
	localparam int SCM_MD_TXEN = 2;
	localparam int SCM_MD_RXEN = 3;
	localparam int SCM_MD_DIAG_LO = 4;
	localparam int SCM_MD_DIAG_HI = 5;
	localparam int SCM_MD_EXTSYNC = 6;
	// status fields
	localparam int SCM_ST_CTSLOST = 0;
	localparam int SCM_ST_CDLOST = 1;
	localparam int SCM_ST_RTS = 2;
	localparam int SCM_ST_CTS = 3;
	localparam int SCM_ST_CD = 4;
	localparam int SCM_ST_TXBUSY = 5;
	// widths and counts
	localparam int SCM_DIV_W = 11;
	localparam logic [1:0] SCM_QUARTER_LAST = 2'h3;
	localparam logic [3:0] SCM_OVERSAMPLE_LAST = 4'hf;
	localparam logic [5:0] SCM_DLY_RTS_ASYNC = 6'h00;
	localparam logic [5:0] SCM_DLY_RTS_SYNC = 6'h01;
	localparam logic [5:0] SCM_DLY_CTS_ASYNC = 6'h30;
	localparam logic [5:0] SCM_DLY_CTS_SYNC = 6'h04;
	localparam logic [2:0] SCM_ABORT_ASYNC = 3'h3;
	localparam logic [2:0] SCM_ABORT_SYNC = 3'h4;
	localparam logic [2:0] SCM_CDLOST_BITS = 3'h4;
	localparam logic [3:0] SCM_FRAME_LAST = 4'h7;
	localparam logic [4:0] SCM_UNIT_NARROW = 5'h08;
	localparam logic [4:0] SCM_UNIT_WIDE = 5'h10;
	typedef enum logic [1:0] {
		SCM_PROT_BITOR = 2'b00,
		SCM_PROT_ASYNC = 2'b01,
		SCM_PROT_SYNCMSG = 2'b10,
		SCM_PROT_TRANSP = 2'b11
	} scm_prot_t;
	typedef enum logic [1:0] {
		SCM_DIAG_NORMAL = 2'b00,
		SCM_DIAG_LOOP = 2'b01,
		SCM_DIAG_ECHO = 2'b10,
		SCM_DIAG_SOFT = 2'b11
	} scm_diag_t;
	typedef enum logic [2:0] {
		SCM_TX_IDLE = 3'b000,
		SCM_TX_RTSW = 3'b001,
		SCM_TX_CTSW = 3'b011,
		SCM_TX_SHIFT = 3'b010,
		SCM_TX_TAIL = 3'b110
	} scm_txst_t;
endpackage
`default_nettype wire

// File: logic/scm_sync2.sv
`timescale 1ns/100ps
`default_nettype none
module scm_sync2 #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// levels
	input wire logic [W-1:0] async,
	output logic [W-1:0] synced
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			meta_ff <= '1;
			sync_ff <= '1;
		end else begin
			meta_ff <= async;
			sync_ff <= meta_ff;
		end
	end
	assign synced = sync_ff;
endmodule
`default_nettype wire

// File: logic/scm_baud_gen.sv
`timescale 1ns/100ps
`default_nettype none
module scm_baud_gen (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// control
	input wire logic srcEn,
	input wire logic quarter,
	input wire logic [scm_pkg::SCM_DIV_W-1:0] divValue,
	// generator outputs
	output logic brgRise,
	output logic brgFall,
	output logic brgClk
);
	import scm_pkg::*;
	logic [1:0] presc_ff, nxt_presc;
	logic [SCM_DIV_W-1:0] cnt_ff, nxt_cnt;
	logic oddPh_ff, nxt_oddPh;
	logic brgClk_ff, nxt_brgClk;
	logic prescEn, tick, fallPulse;
	logic [SCM_DIV_W:0] ratio, fallAt;

	always_comb begin
		prescEn = srcEn && (!quarter || presc_ff == SCM_QUARTER_LAST);
		nxt_presc = presc_ff;
		if (srcEn)
			nxt_presc = quarter ? presc_ff + 2'h1 : 2'h0;
		tick = prescEn && cnt_ff == '0;
		nxt_cnt = cnt_ff;
		// reload reads the live field, so a new value lands at reload
		if (prescEn)
			nxt_cnt = tick ? divValue : cnt_ff - 1'b1;
		// odd ratios alternate the short half between periods
		ratio = {1'b0, divValue} + 1'b1;
		fallAt = (ratio >> 1) + {{SCM_DIV_W{1'b0}}, ratio[0] & oddPh_ff};
		fallPulse = prescEn && {1'b0, cnt_ff} == fallAt;
		nxt_oddPh = tick ? !oddPh_ff : oddPh_ff;
		nxt_brgClk = brgClk_ff;
		if (tick)
			nxt_brgClk = 1'b1;
		else if (fallPulse)
			nxt_brgClk = 1'b0;
		brgRise = tick;
		brgFall = (divValue == '0) ? tick : fallPulse;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			presc_ff <= 2'h0;
			cnt_ff <= '0;
			oddPh_ff <= 1'b0;
			brgClk_ff <= 1'b0;
		end else begin
			presc_ff <= nxt_presc;
			cnt_ff <= nxt_cnt;
			oddPh_ff <= nxt_oddPh;
			brgClk_ff <= nxt_brgClk;
		end
	end
	assign brgClk = brgClk_ff;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	property p_reload;
		prescEn && cnt_ff == '0 |=> cnt_ff == $past(divValue);
	endproperty
	a_reload: assert property (p_reload) else $error("reload missed");
	property p_fastest;
		divValue == '0 && prescEn |-> brgRise && brgFall;
	endproperty
	a_fastest: assert property (p_fastest) else $error("div 1 no tick");
	property p_quarter;
		quarter && $stable(quarter) && prescEn |=> !prescEn [*3];
	endproperty
	a_quarter: assert property (p_quarter) else $error("prescale fast");
	c_tick: cover property (brgRise && divValue == 11'h002);
endmodule
`default_nettype wire

// File: logic/scm_channel.sv
// How it works
// - An 11-bit counter reloads from the divider field at zero, hidden from software.
// - Generator divides the prescaled clock by field plus one, 1 to 2048.
// - Odd ratios alternate the short half so duty averages fifty percent.
// - Prescale select picks divide by one or divide by four before the counter.
// - Asynchronous protocol clocks bits at one sixteenth of the generator rate.
// - A pin clock in asynchronous protocol also gives bits at pin over 16.
// - Synchronous protocols use the chosen clock directly as bit clock.
// - Sixteen-bit mode register clears on reset with protocol, enables, diagnostics.
// - Normal diagnostics let clear-to-send and carrier-detect gate transmit and receive.
// - Request-to-send rises on a falling transmit clock after data is queued.
// - Data starts 0/1 clocks after request, 48/4 after clear-to-send.
// - Request-to-send drops one transmit clock after the frame's last bit.
// - Clear-to-send sampled each rising clock; loss flags and aborts 3/4 bits later.
// - First receive bit latches on the edge seeing carrier, unless external sync.
// - Carrier loss flags, stops within four bits, drops residue below 8/16 bits.
// - Loopback feeds transmitter output to receiver and ignores the data pin.
// - Clearing receive enable drops held data and aborts the character.
// - Clearing transmit enable aborts, empties data and idles the line high.
// - Protocol select: bit-oriented, async, sync message, byte-sync/transparent.
// - Echo retransmits received bits, ignores clear-to-send and transmit enable.
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module scm_channel (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// apb slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// modem pins, active low where marked
	output logic txdOut,
	output logic rtsN,
	input wire logic ctsN,
	input wire logic cdN,
	input wire logic rxdPin,
	input wire logic transmitClockPin,
	input wire logic receiveClockPin,
	input wire logic timerClockInput,
	output logic brgClkOut,
	// transmit stream
	input wire logic [7:0] txData,
	input wire logic txValid,
	output logic txReady,
	// receive stream
	output logic [15:0] rxData,
	output logic rxValid
);
	import scm_pkg::*;

	logic [5:0] pinSync;
	logic ctsNs, cdNs, rxdS, txPinS, rxPinS, timerS;
	logic txPinPrev_ff, rxPinPrev_ff, timerPrev_ff;
	logic brgRise, brgFall, srcEn;
	scm_sync2 #(.W(6)) scm_sync2_i (
		.clk_sys(clk_sys),
		.rst(rst),
		.async({ctsN, cdN, rxdPin, transmitClockPin, receiveClockPin,
			timerClockInput}),
		.synced(pinSync)
	);
	assign {ctsNs, cdNs, rxdS, txPinS, rxPinS, timerS} = pinSync;

	// ---- registers
	logic [15:0] cfg_ff, nxt_cfg, mode_ff, nxt_mode;
	logic [31:0] prdata_ff, nxt_prdata;
	logic ctsLost_ff, nxt_ctsLost, cdLost_ff, nxt_cdLost;
	logic wrEn, hit, setCtsLost, setCdLost, txBusy;
	scm_prot_t prot;
	scm_diag_t diag;
	logic txEn, rxEn, asyncP, extSyncSel;
	logic [15:0] statWord;

	assign prot = scm_prot_t'(mode_ff[SCM_MD_PROT_HI:SCM_MD_PROT_LO]);
	assign diag = scm_diag_t'(mode_ff[SCM_MD_DIAG_HI:SCM_MD_DIAG_LO]);
	assign txEn = mode_ff[SCM_MD_TXEN];
	assign rxEn = mode_ff[SCM_MD_RXEN];
	assign asyncP = prot == SCM_PROT_ASYNC;
	assign extSyncSel = mode_ff[SCM_MD_EXTSYNC]
		&& prot == SCM_PROT_TRANSP;

	always_comb begin
		hit = paddr == SCM_OFS_CLKCFG || paddr == SCM_OFS_MODE
			|| paddr == SCM_OFS_STAT;
		wrEn = psel && penable && pwrite && hit;
		statWord = '0;
		statWord[SCM_ST_CTSLOST] = ctsLost_ff;
		statWord[SCM_ST_CDLOST] = cdLost_ff;
		statWord[SCM_ST_RTS] = !rtsN;
		statWord[SCM_ST_CTS] = !ctsNs;
		statWord[SCM_ST_CD] = !cdNs;
		statWord[SCM_ST_TXBUSY] = txBusy;
		nxt_cfg = cfg_ff;
		nxt_mode = mode_ff;
		if (wrEn && paddr == SCM_OFS_CLKCFG)
			nxt_cfg = pwdata[15:0];
		if (wrEn && paddr == SCM_OFS_MODE)
			nxt_mode = pwdata[15:0];
		// write one to clear; a same-cycle event wins
		nxt_ctsLost = ctsLost_ff;
		nxt_cdLost = cdLost_ff;
		if (wrEn && paddr == SCM_OFS_STAT) begin
			if (pwdata[SCM_ST_CTSLOST])
				nxt_ctsLost = 1'b0;
			if (pwdata[SCM_ST_CDLOST])
				nxt_cdLost = 1'b0;
		end
		if (setCtsLost)
			nxt_ctsLost = 1'b1;
		if (setCdLost)
			nxt_cdLost = 1'b1;
		// read data captured in setup, so access needs no wait
		nxt_prdata = prdata_ff;
		if (psel && !penable) begin
			case (paddr)
				SCM_OFS_CLKCFG: nxt_prdata = {16'h0000, cfg_ff};
				SCM_OFS_MODE: nxt_prdata = {16'h0000, mode_ff};
				SCM_OFS_STAT: nxt_prdata = {16'h0000, statWord};
				default: nxt_prdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cfg_ff <= SCM_CLKCFG_RST;
			mode_ff <= SCM_MODE_RST;
			prdata_ff <= '0;
			ctsLost_ff <= 1'b0;
			cdLost_ff <= 1'b0;
		end else begin
			cfg_ff <= nxt_cfg;
			mode_ff <= nxt_mode;
			prdata_ff <= nxt_prdata;
			ctsLost_ff <= nxt_ctsLost;
			cdLost_ff <= nxt_cdLost;
		end
	end
	assign prdata = prdata_ff;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit;

	// ---- clocking
	assign srcEn = cfg_ff[SCM_CFG_TIMER] ? (timerS && !timerPrev_ff) : 1'b1;
	scm_baud_gen scm_baud_gen_i (
		.clk_sys(clk_sys),
		.rst(rst),
		.srcEn(srcEn),
		.quarter(cfg_ff[SCM_CFG_QUARTER]),
		.divValue(cfg_ff[SCM_CFG_DIV_HI:SCM_CFG_DIV_LO]),
		.brgRise(brgRise),
		.brgFall(brgFall),
		.brgClk(brgClkOut)
	);
	logic txRise, txFall, rxRise, txBitEn, rxBitEn;
	logic [3:0] txSub_ff, nxt_txSub, rxSub_ff, nxt_rxSub;
	always_comb begin
		txRise = cfg_ff[SCM_CFG_TXPIN] ? (txPinS && !txPinPrev_ff) : brgRise;
		txFall = cfg_ff[SCM_CFG_TXPIN] ? (!txPinS && txPinPrev_ff) : brgFall;
		rxRise = cfg_ff[SCM_CFG_RXPIN] ? (rxPinS && !rxPinPrev_ff) : brgRise;
		// async oversamples by 16, sync uses the clock as is
		txBitEn = txRise && (!asyncP || txSub_ff == SCM_OVERSAMPLE_LAST);
		rxBitEn = rxRise && (!asyncP || rxSub_ff == SCM_OVERSAMPLE_LAST);
		nxt_txSub = txRise ? txSub_ff + 4'h1 : txSub_ff;
		nxt_rxSub = rxRise ? rxSub_ff + 4'h1 : rxSub_ff;
	end
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			txPinPrev_ff <= 1'b1;
			rxPinPrev_ff <= 1'b1;
			timerPrev_ff <= 1'b1;
			txSub_ff <= 4'h0;
			rxSub_ff <= 4'h0;
		end else begin
			txPinPrev_ff <= txPinS;
			rxPinPrev_ff <= rxPinS;
			timerPrev_ff <= timerS;
			txSub_ff <= nxt_txSub;
			rxSub_ff <= nxt_rxSub;
		end
	end

	// ---- transmitter
	scm_txst_t txSt_ff, nxt_txSt;
	logic [7:0] txShift_ff, nxt_txShift;
	logic [3:0] txBits_ff, nxt_txBits;
	logic [5:0] txDly_ff, nxt_txDly;
	logic [2:0] abortLeft_ff, nxt_abortLeft;
	logic rts_ff, nxt_rts, txd_ff, nxt_txd, ctsSamp_ff, nxt_ctsSamp;
	logic aborting_ff, nxt_aborting, autoCtl;
	always_comb begin
		autoCtl = diag == SCM_DIAG_NORMAL || diag == SCM_DIAG_LOOP;
		nxt_ctsSamp = ctsSamp_ff;
		if (txRise)
			nxt_ctsSamp = !ctsNs || !autoCtl;
		nxt_txSt = txSt_ff;
		nxt_txShift = txShift_ff;
		nxt_txBits = txBits_ff;
		nxt_txDly = txDly_ff;
		nxt_abortLeft = abortLeft_ff;
		nxt_rts = rts_ff;
		nxt_txd = txd_ff;
		nxt_aborting = aborting_ff;
		setCtsLost = 1'b0;
		txReady = 1'b0;
		if (!txEn || diag == SCM_DIAG_ECHO) begin
			// drop everything queued, idle high
			nxt_txSt = SCM_TX_IDLE;
			nxt_txShift = '0;
			nxt_rts = 1'b0;
			nxt_txd = 1'b1;
			nxt_aborting = 1'b0;
		end else begin
			case (txSt_ff)
				SCM_TX_IDLE: begin
					txReady = 1'b1;
					if (txValid) begin
						nxt_txShift = txData;
						nxt_txSt = SCM_TX_RTSW;
					end
				end
				SCM_TX_RTSW: begin
					if (txFall) begin
						nxt_rts = 1'b1;
						nxt_txDly = asyncP ? SCM_DLY_RTS_ASYNC : SCM_DLY_RTS_SYNC;
						nxt_txSt = SCM_TX_CTSW;
					end
				end
				SCM_TX_CTSW: begin
					// counting restarts while clear-to-send is away
					if (!ctsSamp_ff)
						nxt_txDly = asyncP ? SCM_DLY_CTS_ASYNC : SCM_DLY_CTS_SYNC;
					else if (txDly_ff == '0) begin
						nxt_txSt = SCM_TX_SHIFT;
						nxt_txd = txShift_ff[0];
						// a loss flagged on the last bit must not abort the next frame
						nxt_aborting = 1'b0;
						nxt_txBits = 4'h0;
					end else if (txRise)
						nxt_txDly = txDly_ff - 6'h01;
				end
				SCM_TX_SHIFT: begin
					if (txRise && !nxt_ctsSamp && !aborting_ff) begin
						setCtsLost = 1'b1;
						nxt_aborting = 1'b1;
						nxt_abortLeft = asyncP ? SCM_ABORT_ASYNC : SCM_ABORT_SYNC;
					end
					if (txBitEn) begin
						nxt_txShift = {1'b0, txShift_ff[7:1]};
						nxt_txd = txShift_ff[1];
						nxt_txBits = txBits_ff + 4'h1;
						if (aborting_ff) begin
							nxt_abortLeft = abortLeft_ff - 3'h1;
							if (abortLeft_ff == 3'h1) begin
								nxt_txSt = SCM_TX_IDLE;
								nxt_rts = 1'b0;
								nxt_txd = 1'b1;
								nxt_aborting = 1'b0;
							end
						end else if (txBits_ff == SCM_FRAME_LAST) begin
							nxt_txSt = SCM_TX_TAIL;
							nxt_txd = 1'b1;
						end
					end
				end
				SCM_TX_TAIL: begin
					if (txRise) begin
						nxt_rts = 1'b0;
						nxt_txSt = SCM_TX_IDLE;
					end
				end
				default: nxt_txSt = SCM_TX_IDLE;
			endcase
		end
	end
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			txSt_ff <= SCM_TX_IDLE;
			txShift_ff <= '0;
			txBits_ff <= '0;
			txDly_ff <= '0;
			abortLeft_ff <= '0;
			rts_ff <= 1'b0;
			txd_ff <= 1'b1;
			ctsSamp_ff <= 1'b0;
			aborting_ff <= 1'b0;
		end else begin
			txSt_ff <= nxt_txSt;
			txShift_ff <= nxt_txShift;
			txBits_ff <= nxt_txBits;
			txDly_ff <= nxt_txDly;
			abortLeft_ff <= nxt_abortLeft;
			rts_ff <= nxt_rts;
			txd_ff <= nxt_txd;
			ctsSamp_ff <= nxt_ctsSamp;
			aborting_ff <= nxt_aborting;
		end
	end
	assign txBusy = txSt_ff != SCM_TX_IDLE;
	assign rtsN = !rts_ff;
	assign txdOut = (diag == SCM_DIAG_ECHO) ? rxdS : txd_ff;

	// ---- receiver
	logic [15:0] rxShift_ff, nxt_rxShift, rxData_ff, nxt_rxData;
	logic [4:0] rxCnt_ff, nxt_rxCnt, unit;
	logic [2:0] lostLeft_ff, nxt_lostLeft;
	logic rxAct_ff, nxt_rxAct, losing_ff, nxt_losing, rxArm_ff, nxt_rxArm;
	logic rxValid_ff, nxt_rxValid, rxIn, cdOk;
	always_comb begin
		rxIn = (diag == SCM_DIAG_LOOP) ? txd_ff : rxdS;
		cdOk = !cdNs || diag == SCM_DIAG_SOFT;
		unit = (prot == SCM_PROT_BITOR || prot == SCM_PROT_TRANSP)
			? SCM_UNIT_WIDE : SCM_UNIT_NARROW;
		nxt_rxShift = rxShift_ff;
		nxt_rxData = rxData_ff;
		nxt_rxCnt = rxCnt_ff;
		nxt_lostLeft = lostLeft_ff;
		nxt_rxAct = rxAct_ff;
		nxt_losing = losing_ff;
		nxt_rxArm = rxArm_ff;
		nxt_rxValid = 1'b0;
		setCdLost = 1'b0;
		if (!rxEn) begin
			nxt_rxShift = '0;
			nxt_rxCnt = '0;
			nxt_rxAct = 1'b0;
			nxt_losing = 1'b0;
			nxt_rxArm = 1'b0;
		end else if (rxBitEn) begin
			nxt_rxArm = cdOk;
			if (!rxAct_ff) begin
				if (cdOk && (!extSyncSel || rxArm_ff)) begin
					nxt_rxAct = 1'b1;
					nxt_rxShift = {rxIn, 15'h0000};
					nxt_rxCnt = 5'h01;
				end
			end else begin
				nxt_rxShift = {rxIn, rxShift_ff[15:1]};
				nxt_rxCnt = rxCnt_ff + 5'h01;
				if (rxCnt_ff + 5'h01 == unit) begin
					nxt_rxCnt = '0;
					nxt_rxValid = 1'b1;
					nxt_rxData = (unit == SCM_UNIT_WIDE) ? nxt_rxShift
						: {8'h00, nxt_rxShift[15:8]};
				end
				if (losing_ff) begin
					nxt_lostLeft = lostLeft_ff - 3'h1;
					if (lostLeft_ff == 3'h1) begin
						// partial unit thrown away
						nxt_rxAct = 1'b0;
						nxt_losing = 1'b0;
						nxt_rxCnt = '0;
					end
				end else if (!cdOk) begin
					setCdLost = 1'b1;
					nxt_losing = 1'b1;
					nxt_lostLeft = SCM_CDLOST_BITS - 3'h1;
				end
			end
		end
	end
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rxShift_ff <= '0;
			rxData_ff <= '0;
			rxCnt_ff <= '0;
			lostLeft_ff <= '0;
			rxAct_ff <= 1'b0;
			losing_ff <= 1'b0;
			rxArm_ff <= 1'b0;
			rxValid_ff <= 1'b0;
		end else begin
			rxShift_ff <= nxt_rxShift;
			rxData_ff <= nxt_rxData;
			rxCnt_ff <= nxt_rxCnt;
			lostLeft_ff <= nxt_lostLeft;
			rxAct_ff <= nxt_rxAct;
			losing_ff <= nxt_losing;
			rxArm_ff <= nxt_rxArm;
			rxValid_ff <= nxt_rxValid;
		end
	end
	assign rxData = rxData_ff;
	assign rxValid = rxValid_ff;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	property p_mode_wr;
		wrEn && paddr == SCM_OFS_MODE |=> mode_ff == $past(pwdata[15:0]);
	endproperty
	a_mode_wr: assert property (p_mode_wr) else $error("mode lost");
	property p_rts_on;
		txEn && diag != SCM_DIAG_ECHO && txSt_ff == SCM_TX_RTSW && txFall
			|=> !rtsN && txSt_ff == SCM_TX_CTSW;
	endproperty
	a_rts_on: assert property (p_rts_on) else $error("rts late");
	property p_rts_off;
		txEn && diag != SCM_DIAG_ECHO && txSt_ff == SCM_TX_TAIL && txRise
			|=> rtsN && txSt_ff == SCM_TX_IDLE;
	endproperty
	a_rts_off: assert property (p_rts_off) else $error("rts held");
	property p_cts_lost;
		txEn && diag == SCM_DIAG_NORMAL && txSt_ff == SCM_TX_SHIFT && txRise
			&& ctsNs && !aborting_ff |=> ctsLost_ff && aborting_ff;
	endproperty
	a_cts_lost: assert property (p_cts_lost) else $error("no cts lost");
	property p_tx_off;
		!txEn |=> txdOut || diag == SCM_DIAG_ECHO ##0 rtsN && !txBusy;
	endproperty
	a_tx_off: assert property (p_tx_off) else $error("tx not idle");
	property p_rx_off;
		!rxEn |=> !rxAct_ff && rxCnt_ff == '0 ##1 !rxValid;
	endproperty
	a_rx_off: assert property (p_rx_off) else $error("rx not idle");
	property p_loop;
		diag == SCM_DIAG_LOOP |-> rxIn == txd_ff;
	endproperty
	a_loop: assert property (p_loop) else $error("loop path");
	property p_echo;
		diag == SCM_DIAG_ECHO |-> txdOut == rxdS && rtsN;
	endproperty
	a_echo: assert property (p_echo) else $error("echo path");
	c_frame: cover property (txSt_ff == SCM_TX_TAIL ##[1:300] rtsN);
	c_ctslost: cover property ($rose(ctsLost_ff));
	c_cdlost: cover property ($rose(cdLost_ff));
	c_rxword: cover property (rxValid && prot == SCM_PROT_ASYNC);
endmodule
`default_nettype wire

// File: verification/scm_modem_model.sv
`timescale 1ns/100ps
`default_nettype none
module scm_modem_model (
	// clock
	input wire logic clk_sys,
	// controls from the bench
	input wire logic ctsDrop,
	input wire logic cdOff,
	input wire logic rxdLevel,
	// modem pins
	output logic ctsN,
	output logic cdN,
	output logic rxdPin,
	output logic transmitClockPin,
	output logic receiveClockPin,
	output logic timerClockInput
);
	// pin clocks are not selected, so they stand still at idle
	assign transmitClockPin = 1'b1;
	assign receiveClockPin = 1'b1;
	assign timerClockInput = 1'b0;
	assign rxdPin = rxdLevel;
	// modem answers from a register, as a real line interface would
	always_ff @(posedge clk_sys) begin
		ctsN <= ctsDrop;
		cdN <= cdOff;
	end
endmodule
`default_nettype wire

// File: verification/scm_channel_tb.sv
`timescale 1ns/100ps
`default_nettype none
module scm_channel_tb;
	import scm_pkg::*;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, se, txdOut, rtsN, ctsN, cdN, rxdPin;
	logic tcPin, rcPin, tmPin, brgClkOut, txReady, rxValid;
	logic [15:0] rxData;
	logic [7:0] txData = 8'h00;
	logic txValid = 1'b0;
	logic ctsDrop = 1'b0;
	logic rxdLevel = 1'b1;
	logic cdOff = 1'b0;
	int failCount = 0;
	int nTests = 0;
	always #5 clk_sys = ~clk_sys;
	scm_channel scm_channel_i (.clk_sys(clk_sys), .rst(rst), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .txdOut(txdOut),
		.rtsN(rtsN), .ctsN(ctsN), .cdN(cdN), .rxdPin(rxdPin),
		.transmitClockPin(tcPin), .receiveClockPin(rcPin),
		.timerClockInput(tmPin), .brgClkOut(brgClkOut), .txData(txData),
		.txValid(txValid), .txReady(txReady), .rxData(rxData),
		.rxValid(rxValid));
	scm_modem_model scm_modem_model_i (.clk_sys(clk_sys), .ctsDrop(ctsDrop),
		.cdOff(cdOff), .rxdLevel(rxdLevel), .ctsN(ctsN), .cdN(cdN),
		.rxdPin(rxdPin), .transmitClockPin(tcPin), .receiveClockPin(rcPin),
		.timerClockInput(tmPin));
	task automatic reportAndStop;
		$display("checks %0d mismatches %0d", nTests, failCount);
		if (failCount == 0 && nTests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, exp, input string msg);
		nTests++;
		if (got !== exp) begin
			failCount++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask
	task automatic tmo;
		failCount++;
		$display("CHECK FAILED %0t wait ran out", $time);
		reportAndStop();
	endtask
	task automatic apb(input logic [7:0] a, input logic w,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			tmo();
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic waitLvl(input logic lvl);
		int n;
		n = 0;
		while (brgClkOut !== lvl && n < 20000) begin
			@(negedge clk_sys);
			n++;
		end
		if (brgClkOut !== lvl)
			tmo();
	endtask
	task automatic rise;
		waitLvl(1'b0);
		waitLvl(1'b1);
	endtask
	task automatic fall;
		waitLvl(1'b1);
		waitLvl(1'b0);
	endtask
	task automatic waitRts(input logic lvl);
		int n;
		n = 0;
		do begin
			@(negedge clk_sys);
			n++;
		// old divider may still be counting down from a long value
		end while (rtsN !== lvl && n < 5000);
		if (rtsN !== lvl)
			tmo();
	endtask
	task automatic brg(input logic [10:0] dv, input logic q);
		int f, per, hi, e;
		logic last;
		f = (dv + 1) * (q ? 4 : 1);
		apb(SCM_OFS_CLKCFG, 1'b1, {20'h0, dv, q});
		// skip the countdown that still runs from the old divider
		rise();
		rise();
		per = 0;
		hi = 0;
		e = 0;
		last = 1'b1;
		while (e < 2 && per < 20000) begin
			@(negedge clk_sys);
			per++;
			hi += brgClkOut;
			if (brgClkOut && !last)
				e++;
			last = brgClkOut;
		end
		chk(per, 2 * f, "brg period");
		chk(hi, f, "brg duty");
	endtask
	task automatic sendByte(input logic [7:0] b);
		int n;
		n = 0;
		@(posedge clk_sys);
		txData <= b;
		txValid <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (txReady !== 1'b1 && n < 100);
		if (n >= 100)
			tmo();
		txValid <= 1'b0;
		waitRts(1'b0);
	endtask
	task automatic frame(input logic [7:0] b);
		logic [7:0] got;
		sendByte(b);
		rise();
		for (int i = 0; i < 8; i++) begin
			fall();
			got[i] = txdOut;
		end
		chk(got, b, "tx bits");
		rise();
		fall();
		chk(rtsN, 1'b0, "rts early");
		rise();
		fall();
		chk(rtsN, 1'b1, "rts late");
	endtask
	initial begin
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		apb(SCM_OFS_CLKCFG, 1'b0, 32'h0);
		chk(rd, 32'h4, "cfg reset");
		apb(SCM_OFS_MODE, 1'b0, 32'h0);
		chk(rd, 32'h0, "mode reset");
		apb(8'h0c, 1'b1, 32'h1234);
		chk(se, 1'b1, "unmapped err");
		apb(8'h0c, 1'b0, 32'h0);
		chk(rd, 32'h0, "unmapped read");
		for (int p = 0; p < 4; p++) begin
			apb(SCM_OFS_MODE, 1'b1, 32'h30 | p);
			apb(SCM_OFS_MODE, 1'b0, 32'h0);
			chk(rd, 32'h30 | p, "mode rw");
		end
		brg(11'h002, 1'b0);
		brg(11'h004, 1'b0);
		brg(11'h003, 1'b1);
		brg(11'h7ff, 1'b0);
		apb(SCM_OFS_CLKCFG, 1'b1, 32'h6);
		apb(SCM_OFS_MODE, 1'b1, 32'h6);
		frame(8'h4b);
		frame(8'hd2);
		// lost clear-to-send in mid-frame
		sendByte(8'hff);
		repeat (3) rise();
		@(posedge clk_sys);
		ctsDrop <= 1'b1;
		repeat (3) rise();
		chk(rtsN, 1'b0, "abort too soon");
		waitRts(1'b1);
		chk(txdOut, 1'b1, "abort idle");
		apb(SCM_OFS_STAT, 1'b0, 32'h0);
		chk(rd & 32'h1, 32'h1, "cts lost flag");
		apb(SCM_OFS_STAT, 1'b1, 32'h1);
		apb(SCM_OFS_STAT, 1'b0, 32'h0);
		chk(rd & 32'h1, 32'h0, "cts lost clear");
		ctsDrop <= 1'b0;
		// transmitter disabled with zeros on the line
		sendByte(8'h00);
		repeat (7) rise();
		chk(txdOut, 1'b0, "tx low");
		apb(SCM_OFS_MODE, 1'b1, 32'h2);
		repeat (3) @(posedge clk_sys);
		chk({txdOut, rtsN, txReady}, 3'b110, "tx disable");
		// echo ignores clear-to-send and transmit enable
		apb(SCM_OFS_MODE, 1'b1, 32'h20);
		ctsDrop <= 1'b1;
		for (int v = 0; v < 2; v++) begin
			@(posedge clk_sys);
			rxdLevel <= v[0];
			repeat (5) @(posedge clk_sys);
			chk(txdOut, v[0], "echo");
		end
		chk(txReady, 1'b0, "echo ready");
		// loopback ignores the data pin and still delivers words
		ctsDrop <= 1'b0;
		rxdLevel <= 1'b0;
		// idle transmitter looped back: ones although the pin is low
		apb(SCM_OFS_MODE, 1'b1, 32'h1a);
		for (int n = 0; n < 300 && rxValid !== 1'b1; n++)
			@(posedge clk_sys);
		chk(rxData, 16'h00ff, "loop data");
		apb(SCM_OFS_MODE, 1'b1, 32'h1e);
		sendByte(8'h5a);
		for (int n = 0; n < 300 && rxValid !== 1'b1; n++)
			@(posedge clk_sys);
		chk(rxValid, 1'b1, "loop word");
		// carrier drops while the receiver is busy
		cdOff <= 1'b1;
		repeat (3) rise();
		apb(SCM_OFS_STAT, 1'b0, 32'h0);
		chk(rd & 32'h2, 32'h2, "cd lost flag");
		reportAndStop();
	end
endmodule
`default_nettype wire
